// file: hdl/fsp_defines.svh
// constants for the fault status packer: framing characters, bit positions, counts
// assumes 7-bit ascii characters carried in the low bits of a byte
//
// Function
// - tx async field only when tx async
// - suppressed field still emits its comma
// - rx async field only when rx async
// - tx drop-insert field needs card and mode
// - rx drop-insert field needs card and mode
// - tx intermediate-rate field needs card, mode
// - rx intermediate-rate field needs card, mode
// - card-only fields need card installed
// - async-either field needs card, either async
// - drop-insert-either field needs card, either mode
// - fault query framed, reply framed with 17 chars
// - faults packed as bits in characters
// - fault bit one when present
// - char a: module fault, actual output state
// - char a low nibble: mod count 0..10
// - char b: synth, i, q, gain bits
// - char c: only bit six set
// - char d: demod fault, carrier detect
// - char d low nibble: demod count 0..10
// - char e: synth lock, i, q, error rate
// - char g: tx interface fault, count
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

`define FSP_CH_START     8'h3c
`define FSP_CH_REPLY     8'h3e
`define FSP_CH_SLASH     8'h2f
`define FSP_CH_COMMA     8'h2c
`define FSP_CH_CR        8'h0d
`define FSP_CH_LF        8'h0a
`define FSP_CMD_STRING   40'h424353465f
`define FSP_CMD_LEN      3'h5
`define FSP_ADDR_LEN     2'h3
`define FSP_NUM_CHARS    17
`define FSP_AUX_CHARS    10
`define FSP_REPLY_LEN    5'h1d
`define FSP_FIRST_STAT   5'h0a
`define FSP_COUNT_MAX    4'ha
`define FSP_BIT_FIXED    6
`define FSP_BIT_5        5
`define FSP_BIT_4        4
`define FSP_BIT_3        3
`define FSP_BIT_2        2
`define FSP_BIT_1        1
`define FSP_BIT_0        0
`define FSP_CHAR_BASE    7'h40

`endif

// file: hdl/fsp_pkg.sv
// types shared by the fault status packer modules
// assumes fsp_defines.svh for numeric constants
package fsp_pkg;

  typedef enum logic [1:0] {
    FSP_OVH_NONE,
    FSP_OVH_ASYNC,
    FSP_OVH_DROP_INSERT,
    FSP_OVH_INTERMEDIATE_RATE
  } fsp_ovh_t;

  typedef enum logic [3:0] {
    FSP_FC_ALWAYS,
    FSP_FC_TX_ASYNC,
    FSP_FC_RX_ASYNC,
    FSP_FC_TX_DROP_INSERT,
    FSP_FC_RX_DROP_INSERT,
    FSP_FC_TX_INTERMEDIATE_RATE,
    FSP_FC_RX_INTERMEDIATE_RATE,
    FSP_FC_CARD,
    FSP_FC_ANY_ASYNC,
    FSP_FC_ANY_DROP_INSERT
  } fsp_field_class_t;

  typedef struct packed {
    logic       mod_fault;
    logic       tx_out_on;
    logic [3:0] mod_count;
    logic       mod_if_synth;
    logic       mod_data_clk_synth;
    logic       mod_i_chan;
    logic       mod_q_chan;
    logic       mod_gain_level;
    logic       demod_fault;
    logic       carrier_detect;
    logic [3:0] demod_count;
    logic       demod_if_synth_lock;
    logic       demod_i_chan;
    logic       demod_q_chan;
    logic       demod_error_rate;
    logic       tx_if_fault;
    logic [3:0] tx_if_count;
    logic [59:0] aux;
  } fsp_faults_t;

  typedef logic [6:0] fsp_char_t;

endpackage : fsp_pkg

// file: hdl/fsp_fault_if.sv
// carries live fault levels to the character packer and the packed characters back
// assumes both ends in the clk domain of the top module
`timescale 1ns/1ns
`include "fsp_defines.svh"
interface fsp_fault_if;
  import fsp_pkg::*;

  fsp_faults_t flt;
  fsp_char_t   chr [`FSP_NUM_CHARS];

  modport packer (input flt, output chr);
  modport user   (output flt, input chr);
endinterface : fsp_fault_if

// file: hdl/fsp_char_pack.sv
// packs fault levels into the printable status characters of the consolidated reply
// assumes fault levels already synchronous to the top module clock
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_char_pack (
  // fault levels in, characters out
  fsp_fault_if.packer fi
);
  import fsp_pkg::*;

  // counts above the documented ceiling are clamped rather than wrapped
  function automatic logic [3:0] fsp_clamp(input logic [3:0] c);
    fsp_clamp = (c > `FSP_COUNT_MAX) ? `FSP_COUNT_MAX : c;
  endfunction : fsp_clamp

  function automatic fsp_char_t fsp_ch(input logic [5:0] bits);
    fsp_ch = `FSP_CHAR_BASE | {1'b0, bits};
  endfunction : fsp_ch

  always_comb begin
    // character a
    fi.chr[0] = fsp_ch({fi.flt.mod_fault, fi.flt.tx_out_on,
                        fsp_clamp(fi.flt.mod_count)});
    // character b, reserved bit four held low
    fi.chr[1] = fsp_ch({fi.flt.mod_if_synth, 1'b0,
                        fi.flt.mod_data_clk_synth,
                        fi.flt.mod_i_chan, fi.flt.mod_q_chan,
                        fi.flt.mod_gain_level});
    fi.chr[2] = fsp_ch(6'h00);
    fi.chr[3] = fsp_ch({fi.flt.demod_fault, fi.flt.carrier_detect,
                        fsp_clamp(fi.flt.demod_count)});
    fi.chr[4] = fsp_ch({fi.flt.demod_if_synth_lock, 1'b0,
                        fi.flt.demod_i_chan, fi.flt.demod_q_chan, 1'b0,
                        fi.flt.demod_error_rate});
    fi.chr[5] = fsp_ch(6'h00);
    fi.chr[6] = fsp_ch({fi.flt.tx_if_fault, 1'b0,
                        fsp_clamp(fi.flt.tx_if_count)});
    // later characters come from neighbouring status sources
    for (int i = 0; i < `FSP_AUX_CHARS; i++) begin
      fi.chr[7 + i] = fsp_ch(fi.flt.aux[6 * i +: 6]);
    end
  end

endmodule : fsp_char_pack

// file: hdl/fsp_top.sv
// fault status packer: answers the consolidated fault query and gates
// conditional configuration fields on their way to the serial transmitter
// assumes rx bytes arrive one per rx_valid pulse; tx is valid/ready, held until taken
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_top (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // received command bytes
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_data,
  // own address, three characters, first in the top byte
  input  wire logic [23:0]               dev_addr,
  // response byte stream
  output logic                           tx_valid,
  output logic [7:0]                     tx_data,
  input  wire logic                      tx_ready,
  // configuration field stream from the controller
  input  wire logic                      cfg_valid,
  input  wire logic [7:0]                cfg_data,
  input  wire fsp_pkg::fsp_field_class_t cfg_class,
  output logic                           cfg_ready,
  output logic                           cfg_dropped,
  // overhead configuration and option card
  input  wire fsp_pkg::fsp_ovh_t         tx_ovh,
  input  wire fsp_pkg::fsp_ovh_t         rx_ovh,
  input  wire logic                      card_present,
  // fault levels
  input  wire logic                      mod_fault,
  input  wire logic                      tx_out_on,
  input  wire logic [3:0]                mod_count,
  input  wire logic                      mod_if_synth,
  input  wire logic                      mod_data_clk_synth,
  input  wire logic                      mod_i_chan,
  input  wire logic                      mod_q_chan,
  input  wire logic                      mod_gain_level,
  input  wire logic                      demod_fault,
  input  wire logic                      carrier_detect,
  input  wire logic [3:0]                demod_count,
  input  wire logic                      demod_if_synth_lock,
  input  wire logic                      demod_i_chan,
  input  wire logic                      demod_q_chan,
  input  wire logic                      demod_error_rate,
  input  wire logic                      tx_if_fault,
  input  wire logic [3:0]                tx_if_count,
  input  wire logic [59:0]               aux_fault,
  // status
  output logic                           reply_busy,
  output logic                           reply_done
);
  import fsp_pkg::*;

  typedef enum logic [2:0] {
    FSP_ST_IDLE,
    FSP_ST_ADDR,
    FSP_ST_CMD,
    FSP_ST_CR,
    FSP_ST_SEND
  } fsp_state_t;

  fsp_state_t  state;
  logic [2:0]  pos;
  logic        addr_ok;
  logic [4:0]  reply_idx;
  fsp_char_t   snap [`FSP_NUM_CHARS];
  logic        slot_free;
  logic        take_cfg;
  logic        start_reply;
  logic        load_reply;
  logic        last_reply;
  logic        cfg_pass;

  fsp_fault_if fi ();

  assign fi.flt.mod_fault           = mod_fault;
  assign fi.flt.tx_out_on           = tx_out_on;
  assign fi.flt.mod_count           = mod_count;
  assign fi.flt.mod_if_synth        = mod_if_synth;
  assign fi.flt.mod_data_clk_synth  = mod_data_clk_synth;
  assign fi.flt.mod_i_chan          = mod_i_chan;
  assign fi.flt.mod_q_chan          = mod_q_chan;
  assign fi.flt.mod_gain_level      = mod_gain_level;
  assign fi.flt.demod_fault         = demod_fault;
  assign fi.flt.carrier_detect      = carrier_detect;
  assign fi.flt.demod_count         = demod_count;
  assign fi.flt.demod_if_synth_lock = demod_if_synth_lock;
  assign fi.flt.demod_i_chan        = demod_i_chan;
  assign fi.flt.demod_q_chan        = demod_q_chan;
  assign fi.flt.demod_error_rate    = demod_error_rate;
  assign fi.flt.tx_if_fault         = tx_if_fault;
  assign fi.flt.tx_if_count         = tx_if_count;
  assign fi.flt.aux                 = aux_fault;

  fsp_char_pack u_pack (
    .fi (fi.packer)
  );

  // address character at position p, first character in the top byte
  function automatic logic [7:0] fsp_addr_char(input logic [23:0] a, input logic [2:0] p);
    unique case (p)
      3'h0:    fsp_addr_char = a[23:16];
      3'h1:    fsp_addr_char = a[15:8];
      3'h2:    fsp_addr_char = a[7:0];
      default: fsp_addr_char = 8'h00;
    endcase
  endfunction : fsp_addr_char

  function automatic logic [7:0] fsp_cmd_char(input logic [2:0] p);
    logic [39:0] s;
    s = `FSP_CMD_STRING;
    unique case (p)
      3'h0:    fsp_cmd_char = s[39:32];
      3'h1:    fsp_cmd_char = s[31:24];
      3'h2:    fsp_cmd_char = s[23:16];
      3'h3:    fsp_cmd_char = s[15:8];
      3'h4:    fsp_cmd_char = s[7:0];
      default: fsp_cmd_char = 8'h00;
    endcase
  endfunction : fsp_cmd_char

  // whether a field of the given class may show its value
  function automatic logic fsp_field_on(input fsp_field_class_t c, input fsp_ovh_t t,
                                        input fsp_ovh_t r, input logic card);
    unique case (c)
      FSP_FC_ALWAYS:               fsp_field_on = 1'b1;
      FSP_FC_TX_ASYNC:             fsp_field_on = (t == FSP_OVH_ASYNC);
      FSP_FC_RX_ASYNC:             fsp_field_on = (r == FSP_OVH_ASYNC);
      FSP_FC_TX_DROP_INSERT:       fsp_field_on = card && (t == FSP_OVH_DROP_INSERT);
      FSP_FC_RX_DROP_INSERT:       fsp_field_on = card && (r == FSP_OVH_DROP_INSERT);
      FSP_FC_TX_INTERMEDIATE_RATE: fsp_field_on = card && (t == FSP_OVH_INTERMEDIATE_RATE);
      FSP_FC_RX_INTERMEDIATE_RATE: fsp_field_on = card && (r == FSP_OVH_INTERMEDIATE_RATE);
      FSP_FC_CARD:                 fsp_field_on = card;
      FSP_FC_ANY_ASYNC:            fsp_field_on = card && (t == FSP_OVH_ASYNC ||
                                                           r == FSP_OVH_ASYNC);
      FSP_FC_ANY_DROP_INSERT:      fsp_field_on = card && (t == FSP_OVH_DROP_INSERT ||
                                                           r == FSP_OVH_DROP_INSERT);
      default:                     fsp_field_on = 1'b0;
    endcase
  endfunction : fsp_field_on

  // character at position i of the framed reply
  function automatic logic [7:0] fsp_reply_char(input logic [4:0] i, input logic [23:0] a,
                                                input fsp_char_t s [`FSP_NUM_CHARS]);
    logic [4:0] k;
    k = i - `FSP_FIRST_STAT;
    if (i == 5'h00) begin
      fsp_reply_char = `FSP_CH_REPLY;
    end else if (i <= 5'h03) begin
      fsp_reply_char = fsp_addr_char(a, 3'(i - 5'h01));
    end else if (i == 5'h04) begin
      fsp_reply_char = `FSP_CH_SLASH;
    end else if (i < `FSP_FIRST_STAT) begin
      fsp_reply_char = fsp_cmd_char(3'(i - 5'h05));
    end else if (k < 5'(`FSP_NUM_CHARS)) begin
      fsp_reply_char = {1'b0, s[k]};
    end else if (i == `FSP_REPLY_LEN - 5'h02) begin
      fsp_reply_char = `FSP_CH_CR;
    end else begin
      fsp_reply_char = `FSP_CH_LF;
    end
  endfunction : fsp_reply_char

  assign slot_free   = !tx_valid || tx_ready;
  assign load_reply  = (state == FSP_ST_SEND) && slot_free;
  assign last_reply  = load_reply && (reply_idx == `FSP_REPLY_LEN - 5'h01);
  assign start_reply = (state == FSP_ST_CR) && rx_valid && (rx_data == `FSP_CH_CR) && addr_ok;
  assign take_cfg    = cfg_valid && cfg_ready;
  // separators always go out so that field positions never shift
  assign cfg_pass    = (cfg_data == `FSP_CH_COMMA) ||
                       fsp_field_on(cfg_class, tx_ovh, rx_ovh, card_present);

  // query parser; bytes arriving during a reply are ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= FSP_ST_IDLE;
      pos     <= 3'h0;
      addr_ok <= 1'b0;
    end else if (state == FSP_ST_SEND) begin
      if (last_reply) begin
        state <= FSP_ST_IDLE;
      end
    end else if (rx_valid) begin
      if (rx_data == `FSP_CH_START) begin
        state   <= FSP_ST_ADDR;
        pos     <= 3'h0;
        addr_ok <= 1'b1;
      end else begin
        unique case (state)
          FSP_ST_IDLE: begin
            state <= FSP_ST_IDLE;
          end
          FSP_ST_ADDR: begin
            addr_ok <= addr_ok && (rx_data == fsp_addr_char(dev_addr, pos));
            if (pos == 3'(`FSP_ADDR_LEN - 2'h1)) begin
              state <= FSP_ST_CMD;
              pos   <= 3'h0;
            end else begin
              pos <= pos + 3'h1;
            end
          end
          FSP_ST_CMD: begin
            if (rx_data != fsp_cmd_char(pos)) begin
              state <= FSP_ST_IDLE;
            end else if (pos == `FSP_CMD_LEN - 3'h1) begin
              state <= FSP_ST_CR;
            end else begin
              pos <= pos + 3'h1;
            end
          end
          FSP_ST_CR: begin
            // wrong address still parses but gets no answer
            state <= start_reply ? FSP_ST_SEND : FSP_ST_IDLE;
          end
          FSP_ST_SEND: begin
            state <= FSP_ST_SEND;
          end
        endcase
      end
    end
  end

  // status captured once so a reply is self-consistent even if faults move
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `FSP_NUM_CHARS; i++) begin
        snap[i] <= `FSP_CHAR_BASE;
      end
    end else if (start_reply) begin
      for (int i = 0; i < `FSP_NUM_CHARS; i++) begin
        snap[i] <= fi.chr[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reply_idx <= 5'h00;
    end else if (start_reply) begin
      reply_idx <= 5'h00;
    end else if (load_reply) begin
      reply_idx <= reply_idx + 5'h01;
    end
  end

  // output byte register shared by reply and configuration fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else if (load_reply) begin
      tx_valid <= 1'b1;
      tx_data  <= fsp_reply_char(reply_idx, dev_addr, snap);
    end else if (take_cfg && cfg_pass) begin
      tx_valid <= 1'b1;
      tx_data  <= cfg_data;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // ready only when the output register is sure to be empty next cycle;
  // costs one idle cycle per field but keeps the ready a plain flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ready <= 1'b0;
    end else begin
      cfg_ready <= (state != FSP_ST_SEND) && !start_reply && !take_cfg &&
                   (!tx_valid || tx_ready);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_dropped <= 1'b0;
    end else begin
      cfg_dropped <= take_cfg && !cfg_pass;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reply_busy <= 1'b0;
      reply_done <= 1'b0;
    end else begin
      reply_busy <= start_reply || ((state == FSP_ST_SEND) && !last_reply);
      reply_done <= last_reply;
    end
  end

endmodule : fsp_top

// file: bench/fsp_top_sva.sv
// port checker for the fault status packer top
// assumes binding to fsp_top; one clock domain
`timescale 1ns/1ns
module fsp_top_sva (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      sys_rst,
  // response stream
  input wire logic                      tx_valid,
  input wire logic [7:0]                tx_data,
  input wire logic                      tx_ready,
  // configuration stream
  input wire logic                      cfg_valid,
  input wire logic [7:0]                cfg_data,
  input wire fsp_pkg::fsp_field_class_t cfg_class,
  input wire logic                      cfg_ready,
  input wire logic                      cfg_dropped,
  input wire fsp_pkg::fsp_ovh_t         tx_ovh,
  input wire fsp_pkg::fsp_ovh_t         rx_ovh,
  input wire logic                      card_present,
  // status
  input wire logic                      reply_busy
);
  import fsp_pkg::*;
  logic take;
  logic gate_ok;
  assign take = cfg_valid && cfg_ready;
  // unknown classes count as closed, matching the designer's choice
  always_comb begin
    case (cfg_class)
      FSP_FC_ALWAYS:               gate_ok = 1'b1;
      FSP_FC_TX_ASYNC:             gate_ok = tx_ovh == FSP_OVH_ASYNC;
      FSP_FC_RX_ASYNC:             gate_ok = rx_ovh == FSP_OVH_ASYNC;
      FSP_FC_TX_DROP_INSERT:       gate_ok = card_present && tx_ovh == FSP_OVH_DROP_INSERT;
      FSP_FC_RX_DROP_INSERT:       gate_ok = card_present && rx_ovh == FSP_OVH_DROP_INSERT;
      FSP_FC_TX_INTERMEDIATE_RATE: gate_ok = card_present && tx_ovh == FSP_OVH_INTERMEDIATE_RATE;
      FSP_FC_RX_INTERMEDIATE_RATE: gate_ok = card_present && rx_ovh == FSP_OVH_INTERMEDIATE_RATE;
      FSP_FC_CARD:                 gate_ok = card_present;
      FSP_FC_ANY_ASYNC:            gate_ok = card_present &&
                                             (tx_ovh == FSP_OVH_ASYNC || rx_ovh == FSP_OVH_ASYNC);
      FSP_FC_ANY_DROP_INSERT:      gate_ok = card_present && (tx_ovh == FSP_OVH_DROP_INSERT ||
                                                              rx_ovh == FSP_OVH_DROP_INSERT);
      default:                     gate_ok = 1'b0;
    endcase
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte changed before it was taken");
  property p_reply_start;
    $rose(reply_busy) && !tx_valid |=> tx_valid && tx_data == 8'h3e;
  endproperty
  a_reply_start: assert property (p_reply_start)
    else $error("reply did not open with its start byte");
  property p_comma;
    take && cfg_data == 8'h2c |=> !cfg_dropped && tx_valid && tx_data == 8'h2c;
  endproperty
  a_comma: assert property (p_comma)
    else $error("comma separator was not passed");
  property p_drop_cause;
    cfg_dropped |-> $past(take);
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("drop pulse without a taken byte");
  property p_tx_async;
    take && cfg_data != 8'h2c && cfg_class == FSP_FC_TX_ASYNC
      |=> cfg_dropped == ($past(tx_ovh) != FSP_OVH_ASYNC);
  endproperty
  a_tx_async: assert property (p_tx_async)
    else $error("tx async field gated wrongly");
  property p_rx_async;
    take && cfg_data != 8'h2c && cfg_class == FSP_FC_RX_ASYNC
      |=> cfg_dropped == ($past(rx_ovh) != FSP_OVH_ASYNC);
  endproperty
  a_rx_async: assert property (p_rx_async)
    else $error("rx async field gated wrongly");
  property p_gate;
    take && cfg_data != 8'h2c |=> cfg_dropped == !$past(gate_ok);
  endproperty
  a_gate: assert property (p_gate)
    else $error("conditional field gated wrongly");
  property p_pass;
    take && gate_ok |=> tx_valid && tx_data == $past(cfg_data);
  endproperty
  a_pass: assert property (p_pass)
    else $error("open field not passed to tx");
endmodule : fsp_top_sva

// file: bench/fsp_host.sv
// remote host model: sends framed queries, takes reply bytes, may stall
// assumes the bench sets slow and calls send_query between tests
`timescale 1ns/1ns
module fsp_host (
  // clock
  input wire logic       clk,
  // command link
  output logic           rx_valid,
  output logic [7:0]     rx_data,
  // response link
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  output logic           tx_ready
);
  logic       slow;
  logic [7:0] got [$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end
  always @(negedge clk) begin
    tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
  // idle data flips so a stale byte never reads as fresh
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data  = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~b;
  endtask : send_byte
  task automatic send_query(input logic [23:0] a);
    logic [7:0] q [10];
    q = '{8'h3c, a[23:16], a[15:8], a[7:0], 8'h42, 8'h43, 8'h53, 8'h46, 8'h5f, 8'h0d};
    foreach (q[i]) send_byte(q[i]);
  endtask : send_query
endmodule : fsp_host

// file: bench/fsp_top_tb.sv
// self-checking bench for the fault status packer
// assumes fsp_host as the far side; inputs change at the falling edge
`timescale 1ns/1ns
module fsp_top_tb;
  import fsp_pkg::*;
  logic             clk, sys_rst, rx_valid, tx_valid, tx_ready, cfg_valid, cfg_ready;
  logic             cfg_dropped, card_present, reply_busy, reply_done;
  logic [7:0]       rx_data, tx_data, cfg_data;
  logic [23:0]      dev_addr;
  logic [127:0]     rnd;
  fsp_field_class_t cfg_class, cls;
  fsp_ovh_t         tx_ovh, rx_ovh;
  fsp_faults_t      flt;
  int               err_total, total_checks, drops;

  fsp_top dut_u (.clk, .sys_rst, .rx_valid, .rx_data, .dev_addr, .tx_valid, .tx_data,
    .tx_ready, .cfg_valid, .cfg_data, .cfg_class, .cfg_ready, .cfg_dropped, .tx_ovh,
    .rx_ovh, .card_present, .mod_fault(flt.mod_fault), .tx_out_on(flt.tx_out_on),
    .mod_count(flt.mod_count), .mod_if_synth(flt.mod_if_synth),
    .mod_data_clk_synth(flt.mod_data_clk_synth), .mod_i_chan(flt.mod_i_chan),
    .mod_q_chan(flt.mod_q_chan), .mod_gain_level(flt.mod_gain_level),
    .demod_fault(flt.demod_fault), .carrier_detect(flt.carrier_detect),
    .demod_count(flt.demod_count), .demod_if_synth_lock(flt.demod_if_synth_lock),
    .demod_i_chan(flt.demod_i_chan), .demod_q_chan(flt.demod_q_chan),
    .demod_error_rate(flt.demod_error_rate), .tx_if_fault(flt.tx_if_fault),
    .tx_if_count(flt.tx_if_count), .aux_fault(flt.aux), .reply_busy, .reply_done);
  fsp_host host_u (.clk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cfg_dropped) drops++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  function automatic logic gate(input fsp_field_class_t c, input fsp_ovh_t t,
                                input fsp_ovh_t r, input logic k);
    case (c)
      FSP_FC_ALWAYS:               return 1'b1;
      FSP_FC_TX_ASYNC:             return t == FSP_OVH_ASYNC;
      FSP_FC_RX_ASYNC:             return r == FSP_OVH_ASYNC;
      FSP_FC_TX_DROP_INSERT:       return k && t == FSP_OVH_DROP_INSERT;
      FSP_FC_RX_DROP_INSERT:       return k && r == FSP_OVH_DROP_INSERT;
      FSP_FC_TX_INTERMEDIATE_RATE: return k && t == FSP_OVH_INTERMEDIATE_RATE;
      FSP_FC_RX_INTERMEDIATE_RATE: return k && r == FSP_OVH_INTERMEDIATE_RATE;
      FSP_FC_CARD:                 return k;
      FSP_FC_ANY_ASYNC:            return k && (t == FSP_OVH_ASYNC || r == FSP_OVH_ASYNC);
      FSP_FC_ANY_DROP_INSERT:      return k && (t == FSP_OVH_DROP_INSERT ||
                                                r == FSP_OVH_DROP_INSERT);
      default:                     return 1'b0;
    endcase
  endfunction : gate
  function automatic logic [3:0] clamp(input logic [3:0] v);
    return (v > 4'ha) ? 4'ha : v;
  endfunction : clamp

  task automatic cfg_send(input logic [7:0] b, input fsp_field_class_t c, input logic pass);
    int n;
    int d0;
    n = 0;
    d0 = drops;
    host_u.got.delete();
    @(negedge clk);
    while (!cfg_ready && n < 50) begin
      @(negedge clk);
      n++;
    end
    cfg_valid = 1'b1;
    cfg_data  = b;
    cfg_class = c;
    @(negedge clk);
    cfg_valid = 1'b0;
    cfg_data  = ~b;
    repeat (3) @(negedge clk);
    while (tx_valid && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(host_u.got.size(), pass);
    check(drops - d0, !pass);
    if (pass) check(host_u.got[0], b);
  endtask : cfg_send

  task automatic query(input logic [23:0] a, input logic hit);
    logic [7:0] w [$];
    fsp_faults_t f;
    int n;
    logic seen_done;
    f = flt;
    n = 0;
    seen_done = 1'b0;
    host_u.got.delete();
    w = '{8'h3e, dev_addr[23:16], dev_addr[15:8], dev_addr[7:0], 8'h2f,
          8'h42, 8'h43, 8'h53, 8'h46, 8'h5f};
    w.push_back({2'b01, f.mod_fault, f.tx_out_on, clamp(f.mod_count)});
    w.push_back({2'b01, f.mod_if_synth, 1'b0, f.mod_data_clk_synth, f.mod_i_chan,
                 f.mod_q_chan, f.mod_gain_level});
    w.push_back(8'h40);
    w.push_back({2'b01, f.demod_fault, f.carrier_detect, clamp(f.demod_count)});
    w.push_back({2'b01, f.demod_if_synth_lock, 1'b0, f.demod_i_chan, f.demod_q_chan,
                 1'b0, f.demod_error_rate});
    w.push_back(8'h40);
    w.push_back({2'b01, f.tx_if_fault, 1'b0, clamp(f.tx_if_count)});
    for (int k = 0; k < 10; k++) w.push_back({2'b01, f.aux[6*k +: 6]});
    w.push_back(8'h0d);
    w.push_back(8'h0a);
    host_u.send_query(a);
    // faults move right after the query, so the reply must use the snapshot
    rnd = {$urandom, $urandom, $urandom, $urandom};
    flt = rnd[$bits(fsp_faults_t)-1:0];
    while ((tx_valid || reply_busy || n < 5) && n < 600) begin
      @(negedge clk);
      seen_done = seen_done | reply_done;
      n++;
    end
    check(seen_done, hit);
    check(host_u.got.size(), hit ? 29 : 0);
    if (hit) foreach (w[k]) check(host_u.got[k], w[k]);
  endtask : query

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    cfg_valid = 1'b0;
    cfg_data = 8'h00;
    cfg_class = FSP_FC_ALWAYS;
    tx_ovh = FSP_OVH_NONE;
    rx_ovh = FSP_OVH_NONE;
    card_present = 1'b0;
    dev_addr = 24'h303132;
    flt = '1;
    void'($urandom(32));
    repeat (8) @(negedge clk);
    check({tx_valid, tx_data, cfg_ready, cfg_dropped, reply_busy, reply_done}, 0);
    sys_rst = 1'b0;
    for (int i = 0; i < 66; i++) begin
      tx_ovh = fsp_ovh_t'($urandom_range(0, 3));
      rx_ovh = fsp_ovh_t'($urandom_range(0, 3));
      card_present = 1'($urandom_range(0, 1));
      host_u.slow = i[0];
      cls = fsp_field_class_t'(i % 11);
      cfg_send(8'h30 + 8'($urandom_range(0, 9)), cls,
               gate(cls, tx_ovh, rx_ovh, card_present));
      cfg_send(8'h2c, cls, 1'b1);
    end
    $display("config field test done");
    // start byte and first address byte only, then the first query's start byte must restart the parser
    host_u.send_byte(8'h3c);
    host_u.send_byte(dev_addr[23:16]);
    for (int i = 0; i < 10; i++) begin
      host_u.slow = i[1];
      query((i % 4 == 3) ? dev_addr ^ 24'h000100 : dev_addr, i % 4 != 3);
      if (i == 0) flt = '0;
    end
    $display("fault query test done");
    conclude();
  end
endmodule : fsp_top_tb

bind fsp_top fsp_top_sva chk_u (.clk, .sys_rst, .tx_valid, .tx_data, .tx_ready, .cfg_valid,
  .cfg_data, .cfg_class, .cfg_ready, .cfg_dropped, .tx_ovh, .rx_ovh, .card_present,
  .reply_busy);
